// >>> eec_pkg.sv
// Function
// [RULE1] sample serial input bits on every rising serial-clock edge, both modes
// [RULE2] change the serial output bit on every falling serial-clock edge
// [RULE3] chip select high: output high impedance, standby unless a write cycle runs
// [RULE4] host frames each command with a chip-select fall and a chip-select rise
// [RULE5] protect pin high adds no restriction to permitted writes
// [RULE6] pause input low freezes the transfer; sequence state is kept
// [RULE7] first eight bits form the instruction; unknown codes are ignored
// [RULE8] control codes: set latch 06h, clear latch 04h, status write 01h
// [RULE9] access codes: status read 05h, memory read 03h, memory write 02h
// [RULE10] read needs opcode and address; write needs latch, opcode, address, data
// [RULE11] bits 7..0: pin enable, id select, fast, id lock, bp high, bp low, latch, busy
// [RULE12] busy reads 1 during a write cycle, 0 otherwise; host cannot write it
// [RULE13] enable-write sets the latch, disable-write clears it
// [RULE14] block-protect bits written by status write, kept, make region read-only
// [RULE15] protect code 00 none, 01 top quarter, 10 upper half, 11 all
// [RULE16] fast-cycle bit selects standard timing at 0, at most 3 ms at 1
// [RULE17] write cycle starts at the closing chip-select rise, standard within 10 ms
// [RULE18] pin low and pin enable set: refuse status and protected block writes
// [RULE19] hardware protection off when pin high or pin enable bit is 0
// [RULE20] id select routes access to the id page and clears after each access
// [RULE21] id lock once set makes the id page permanently read-only
// [RULE22] status write setting both id select and id lock changes neither
// [RULE23] 24-bit address, only the low 18 bits select an array location
// [RULE24] during a write cycle every command but status read is ignored
// [RULE25] status write changes only bits 2 through 7
// [RULE26] write load increments the byte index, wrapping inside the 256-byte page
// [RULE27] either clock idle level at selection works identically
// [RULE28] a command cut short by chip select rising has no effect
package eec_pkg;
    // ==========================================================
    // opcodes
    localparam logic [7:0] OPC_WE_SET = 8'h06;
    localparam logic [7:0] OPC_WE_CLR = 8'h04;
    localparam logic [7:0] OPC_ST_RD = 8'h05;
    localparam logic [7:0] OPC_ST_WR = 8'h01;
    localparam logic [7:0] OPC_MEM_RD = 8'h03;
    localparam logic [7:0] OPC_MEM_WR = 8'h02;
    // ==========================================================
    // status register layout
    localparam int ST_BUSY = 0;
    localparam int ST_LATCH = 1;
    localparam int ST_BP_LO = 2;
    localparam int ST_BP_HI = 3;
    localparam int ST_LOCK = 4;
    localparam int ST_FAST = 5;
    localparam int ST_IDSEL = 6;
    localparam int ST_PPEN = 7;
    localparam logic [7:0] ST_WR_MASK = 8'hFC;
    localparam logic [7:0] ST_RESET = 8'h00;
    // ==========================================================
    // address geometry and protected regions
    localparam int ADDR_BITS = 24;
    localparam int ARRAY_BITS = 18;
    localparam int PAGE_BITS = 8;
    localparam logic [ARRAY_BITS-1:0] PROT_QUARTER = 18'h3_0000;
    localparam logic [ARRAY_BITS-1:0] PROT_HALF = 18'h2_0000;
    localparam logic [4:0] LAST_BYTE_BIT = 5'h07;
    localparam logic [4:0] LAST_ADDR_BIT = 5'h17;
    // ==========================================================
    // write cycle timing
    localparam int REF_CLK_NS = 100;
    localparam int WC_STD_MS = 10;
    localparam int WC_FAST_MS = 3;
    localparam int WC_STD_CYC = WC_STD_MS * 1000000 / REF_CLK_NS;
    localparam int WC_FAST_CYC = WC_FAST_MS * 1000000 / REF_CLK_NS;
    localparam int TMR_W = 17;

    typedef enum logic [2:0] {
        CMD_NONE = 3'b000,
        CMD_WE_SET = 3'b001,
        CMD_WE_CLR = 3'b010,
        CMD_ST_RD = 3'b011,
        CMD_ST_WR = 3'b100,
        CMD_MEM_RD = 3'b101,
        CMD_MEM_WR = 3'b110
    } eec_cmd_t;

    typedef enum logic [1:0] {
        PH_OPCODE = 2'b00,
        PH_ADDR = 2'b01,
        PH_DATA = 2'b10,
        PH_IDLE = 2'b11
    } eec_phase_t;

    function automatic eec_cmd_t opcode_decode(input logic [7:0] op);
        case (op)
            OPC_WE_SET: return CMD_WE_SET;
            OPC_WE_CLR: return CMD_WE_CLR;
            OPC_ST_RD: return CMD_ST_RD;
            OPC_ST_WR: return CMD_ST_WR;
            OPC_MEM_RD: return CMD_MEM_RD;
            OPC_MEM_WR: return CMD_MEM_WR;
            default: return CMD_NONE;
        endcase
    endfunction

    function automatic logic prot_hit(input logic [1:0] bp, input logic [ARRAY_BITS-1:0] a,
        input logic id);
        if (id)
        begin
            return bp == 2'b11;
        end
        case (bp)
            2'b00: return 1'b0;
            2'b01: return a >= PROT_QUARTER;
            2'b10: return a >= PROT_HALF;
            default: return 1'b1;
        endcase
    endfunction
endpackage

// >>> eec_tx_if.sv
`timescale 1ns/1ps
interface eec_tx_if;
    logic tx_bit;
    logic tx_en;
    modport src (output tx_bit, output tx_en);
    modport stg (input tx_bit, input tx_en);
endinterface

// >>> eec_sync.sv
`timescale 1ns/1ps
module eec_sync
#(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } eec_sync_t;
    eec_sync_t r;
    eec_sync_t next_r;

    always_comb
    begin
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            r <= {INIT, INIT};
        else
            r <= next_r;
    end

    assign q = r.s2;
endmodule // eec_sync

// >>> eec_so_stage.sv
`timescale 1ns/1ps
module eec_so_stage
(
    input wire logic sck,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic hold_n,
    eec_tx_if.stg tx,
    output logic so_out,
    output logic so_oe
);
    typedef struct packed {
        logic out;
        logic oe;
    } eec_so_t;
    eec_so_t r;
    eec_so_t next_r;
    logic off;

    // deselect or pause floats the pin at once, with no clock edge needed
    assign off = rst | cs_n | ~hold_n; // RULE3 RULE6

    always_comb
    begin
        next_r.out = tx.tx_bit;
        next_r.oe = tx.tx_en;
    end

    always_ff @(negedge sck or posedge off) // RULE2
    begin
        if (off)
            r <= '0;
        else
            r <= next_r;
    end

    assign so_out = r.out;
    assign so_oe = r.oe;
endmodule // eec_so_stage

// >>> eec_top.sv
`timescale 1ns/1ps
module eec_top
#(
    parameter int WC_STD_CYCLES = eec_pkg::WC_STD_CYC,
    parameter int WC_FAST_CYCLES = eec_pkg::WC_FAST_CYC
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic spi_sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so_out,
    output logic so_oe,
    input wire logic wp_n,
    input wire logic hold_n,
    input wire logic [7:0] rd_data,
    output logic [eec_pkg::ARRAY_BITS-1:0] rd_addr,
    output logic rd_id,
    output logic load_we,
    output logic [eec_pkg::PAGE_BITS-1:0] load_idx,
    output logic [7:0] load_data,
    output logic pgm_start,
    output logic [eec_pkg::ARRAY_BITS-1:0] pgm_addr,
    output logic pgm_id,
    output logic pgm_fast,
    output logic [7:0] status
);
    import eec_pkg::*;

    if (WC_FAST_CYCLES < 1 || WC_STD_CYCLES < WC_FAST_CYCLES || WC_STD_CYCLES >= 2 ** TMR_W)
    begin : g_bad_timing
        $error("write cycle counts out of range");
    end

    // ==========================================================
    // link side state, clocked by the serial clock
    typedef struct packed {
        eec_phase_t phase;
        logic [4:0] cnt;
        logic [7:0] sh;
        eec_cmd_t cmd;
        logic [ADDR_BITS-1:0] addr;
        logic [PAGE_BITS-1:0] idx;
        logic we;
        logic [PAGE_BITS-1:0] ldi;
        logic [7:0] ldd;
        logic [ARRAY_BITS-1:0] ra;
        logic rid;
    } eec_link_t;

    // finished command, kept past the frame for the core to collect
    typedef struct packed {
        eec_cmd_t cmd;
        logic [7:0] data;
        logic [ARRAY_BITS-1:0] addr;
        logic done;
        logic tog;
    } eec_rec_t;

    typedef struct packed {
        logic [7:0] st;
        logic [TMR_W-1:0] tmr;
        logic cs_prev;
        logic seen;
        logic start;
        logic [ARRAY_BITS-1:0] paddr;
        logic pid;
        logic pfast;
    } eec_core_t;

    eec_link_t lk;
    eec_link_t next_lk;
    eec_rec_t rc;
    eec_rec_t next_rc;
    eec_core_t cr;
    eec_core_t next_cr;
    logic lk_clr;
    logic [7:0] sh_in;
    logic [ADDR_BITS-1:0] addr_in;
    logic [2:0] bitsel;
    logic [7:0] st_s;
    logic [1:0] pins_s;
    logic cs_s;
    logic wp_s;
    logic cs_rise;
    logic hw_prot;
    logic fresh;
    logic [7:0] new_st;
    logic [TMR_W-1:0] wc_load;

    eec_tx_if tx_i();

    // ==========================================================
    // crossings
    eec_sync #(.W(8), .INIT(ST_RESET)) u_st_sync
    (
        .clk(spi_sck),
        .rst(rst),
        .d(cr.st),
        .q(st_s)
    );

    eec_sync #(.W(2), .INIT(2'b11)) u_pin_sync
    (
        .clk(ref_clk),
        .rst(rst),
        .d({cs_n, wp_n}),
        .q(pins_s)
    );

    eec_so_stage u_so
    (
        .sck(spi_sck),
        .rst(rst),
        .cs_n(cs_n),
        .hold_n(hold_n),
        .tx(tx_i.src),
        .so_out(so_out),
        .so_oe(so_oe)
    );

    assign cs_s = pins_s[1];
    assign wp_s = pins_s[0];

    // ==========================================================
    // serial front end
    // deselect clears the frame state asynchronously, so a short command
    // leaves nothing behind and the clock idle level does not matter
    assign lk_clr = rst | cs_n; // RULE27 RULE28
    assign sh_in = {lk.sh[6:0], si}; // RULE1
    assign addr_in = {lk.addr[ADDR_BITS-2:0], si};
    assign bitsel = 3'h7 - lk.cnt[2:0];

    always_comb
    begin
        tx_i.tx_en = (lk.phase == PH_DATA) && (lk.cmd == CMD_ST_RD || lk.cmd == CMD_MEM_RD);
        // array data is read without a clock edge: it must follow rd_addr at once
        tx_i.tx_bit = (lk.cmd == CMD_ST_RD) ? st_s[bitsel] : rd_data[bitsel];
    end

    always_comb
    begin
        next_lk = lk;
        next_rc = rc;
        next_lk.we = 1'b0;
        if (hold_n) // RULE6
        begin
            next_lk.sh = sh_in;
            next_lk.cnt = lk.cnt + 5'h01;
            case (lk.phase)
                PH_OPCODE:
                begin
                    if (lk.cnt == 5'h00)
                        next_rc.done = 1'b0;
                    if (lk.cnt == LAST_BYTE_BIT)
                    begin
                        next_lk.cnt = 5'h00;
                        next_lk.cmd = opcode_decode(sh_in); // RULE7 RULE8 RULE9
                        next_lk.phase = PH_IDLE;
                        if (st_s[ST_BUSY] && next_lk.cmd != CMD_ST_RD) // RULE24
                            next_lk.cmd = CMD_NONE;
                        case (next_lk.cmd)
                            CMD_WE_SET, CMD_WE_CLR:
                            begin
                                next_rc.cmd = next_lk.cmd;
                                next_rc.done = 1'b1;
                                next_rc.tog = ~rc.tog;
                            end
                            CMD_ST_RD, CMD_ST_WR: next_lk.phase = PH_DATA;
                            CMD_MEM_RD, CMD_MEM_WR: next_lk.phase = PH_ADDR; // RULE10
                            default: next_lk.phase = PH_IDLE;
                        endcase
                    end
                end
                PH_ADDR:
                begin
                    next_lk.addr = addr_in;
                    if (lk.cnt == LAST_ADDR_BIT)
                    begin
                        next_lk.cnt = 5'h00;
                        next_lk.phase = PH_DATA;
                        next_lk.ra = addr_in[ARRAY_BITS-1:0]; // RULE23
                        next_lk.rid = st_s[ST_IDSEL]; // RULE20
                        next_lk.idx = addr_in[PAGE_BITS-1:0];
                        if (lk.cmd == CMD_MEM_RD)
                        begin
                            next_rc.cmd = CMD_MEM_RD;
                            next_rc.addr = addr_in[ARRAY_BITS-1:0];
                            next_rc.done = 1'b1;
                            next_rc.tog = ~rc.tog;
                        end
                    end
                end
                PH_DATA:
                begin
                    if (lk.cnt == LAST_BYTE_BIT)
                    begin
                        next_lk.cnt = 5'h00;
                        case (lk.cmd)
                            CMD_ST_WR:
                            begin
                                next_lk.phase = PH_IDLE;
                                next_rc.cmd = CMD_ST_WR;
                                next_rc.data = sh_in;
                                next_rc.done = 1'b1;
                                next_rc.tog = ~rc.tog;
                            end
                            CMD_MEM_WR:
                            begin
                                next_lk.we = 1'b1;
                                next_lk.ldi = lk.idx;
                                next_lk.ldd = sh_in;
                                next_lk.idx = lk.idx + 8'h01; // RULE26
                                next_rc.cmd = CMD_MEM_WR;
                                next_rc.addr = lk.addr[ARRAY_BITS-1:0];
                                next_rc.done = 1'b1;
                                if (!rc.done)
                                    next_rc.tog = ~rc.tog;
                            end
                            CMD_MEM_RD:
                            begin
                                if (lk.rid)
                                    next_lk.ra[PAGE_BITS-1:0] = lk.ra[PAGE_BITS-1:0] + 8'h01;
                                else
                                    next_lk.ra = lk.ra + 18'h0_0001;
                            end
                            default: next_lk.cnt = 5'h00;
                        endcase
                    end
                end
                default: next_lk.cnt = lk.cnt;
            endcase
        end
    end

    always_ff @(posedge spi_sck or posedge lk_clr)
    begin
        if (lk_clr)
            lk <= '0;
        else
            lk <= next_lk;
    end

    always_ff @(posedge spi_sck or posedge rst)
    begin
        if (rst)
            rc <= '0;
        else
            rc <= next_rc;
    end

    // ==========================================================
    // status register and write cycle, on the reference clock
    // rc is only read once the synchronised select has risen, when the
    // serial clock has been still for two reference cycles
    assign cs_rise = cs_s & ~cr.cs_prev; // RULE4
    assign fresh = cs_rise && rc.done && (rc.tog != cr.seen);
    assign hw_prot = cr.st[ST_PPEN] & ~wp_s; // RULE5 RULE19

    always_comb
    begin
        next_cr = cr;
        next_cr.cs_prev = cs_s;
        next_cr.start = 1'b0;
        wc_load = cr.st[ST_FAST] ? TMR_W'(WC_FAST_CYCLES) : TMR_W'(WC_STD_CYCLES); // RULE16
        new_st = (cr.st & ~ST_WR_MASK) | (rc.data & ST_WR_MASK); // RULE25 RULE14
        if (rc.data[ST_IDSEL] && rc.data[ST_LOCK]) // RULE22
        begin
            new_st[ST_IDSEL] = cr.st[ST_IDSEL];
            new_st[ST_LOCK] = cr.st[ST_LOCK];
        end
        new_st[ST_LOCK] = new_st[ST_LOCK] | cr.st[ST_LOCK]; // RULE21
        if (fresh)
            next_cr.seen = rc.tog;
        if (cr.st[ST_BUSY])
        begin
            // the array returns to write disable when the cycle ends
            if (cr.tmr == TMR_W'(1)) // RULE12 RULE17
            begin
                next_cr.st[ST_BUSY] = 1'b0;
                next_cr.st[ST_LATCH] = 1'b0;
            end
            else
                next_cr.tmr = cr.tmr - TMR_W'(1);
        end
        else if (fresh) // RULE24
        begin
            case (rc.cmd)
                CMD_WE_SET: next_cr.st[ST_LATCH] = 1'b1; // RULE13
                CMD_WE_CLR: next_cr.st[ST_LATCH] = 1'b0; // RULE13
                CMD_ST_WR:
                begin
                    if (cr.st[ST_LATCH] && !hw_prot) // RULE18
                    begin
                        next_cr.st = new_st;
                        next_cr.st[ST_BUSY] = 1'b1;
                        next_cr.tmr = wc_load;
                        next_cr.pfast = cr.st[ST_FAST];
                    end
                end
                CMD_MEM_WR:
                begin
                    next_cr.st[ST_IDSEL] = 1'b0; // RULE20
                    if (cr.st[ST_LATCH] && !prot_hit(cr.st[ST_BP_HI:ST_BP_LO], rc.addr,
                        cr.st[ST_IDSEL]) && !(cr.st[ST_IDSEL] && cr.st[ST_LOCK])) // RULE15 RULE21
                    begin
                        next_cr.start = 1'b1; // RULE17
                        next_cr.paddr = rc.addr;
                        next_cr.pid = cr.st[ST_IDSEL];
                        next_cr.pfast = cr.st[ST_FAST];
                        next_cr.st[ST_BUSY] = 1'b1;
                        next_cr.tmr = wc_load;
                    end
                end
                CMD_MEM_RD: next_cr.st[ST_IDSEL] = 1'b0; // RULE20
                default: next_cr.seen = next_cr.seen;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cr <= '0;
            cr.st <= ST_RESET;
            cr.cs_prev <= 1'b1;
        end
        else
            cr <= next_cr;
    end

    assign status = cr.st; // RULE11
    assign rd_addr = lk.ra;
    assign rd_id = lk.rid;
    assign load_we = lk.we;
    assign load_idx = lk.ldi;
    assign load_data = lk.ldd;
    assign pgm_start = cr.start;
    assign pgm_addr = cr.paddr;
    assign pgm_id = cr.pid;
    assign pgm_fast = cr.pfast;

    // ==========================================================
    // checks
    logic [TMR_W-1:0] bcnt;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            bcnt <= '0;
        else
            bcnt <= cr.st[ST_BUSY] ? bcnt + TMR_W'(1) : '0;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_commit(eec_cmd_t c);
        fresh && !cr.st[ST_BUSY] && rc.cmd == c;
    endsequence

    a_latch_set_cmd: assert property (s_commit(CMD_WE_SET) |=> cr.st[ST_LATCH]) // RULE13
        else $error("latch not set");
    a_latch_clr_cmd: assert property (s_commit(CMD_WE_CLR) |=> !cr.st[ST_LATCH]) // RULE13
        else $error("latch not cleared");
    a_sr_hw_lock: assert property ((s_commit(CMD_ST_WR) ##0 hw_prot) |=> $stable(cr.st)) // RULE18
        else $error("status written while pin protected");
    a_sr_bp_write: assert property ((s_commit(CMD_ST_WR) ##0 cr.st[ST_LATCH] // RULE14
        ##0 !hw_prot) |=> cr.st[ST_BP_HI:ST_BP_LO] == $past(rc.data[ST_BP_HI:ST_BP_LO])
        && cr.st[ST_BUSY] && cr.st[ST_LATCH])
        else $error("protect bits not taken");
    a_id_pair_keep: assert property ((s_commit(CMD_ST_WR) ##0 rc.data[ST_IDSEL] // RULE22
        ##0 rc.data[ST_LOCK]) |=> $stable(cr.st[ST_IDSEL]) && $stable(cr.st[ST_LOCK]))
        else $error("id bits changed together");
    // a frame that closes inside a write cycle, before its last reference cycle, must leave the register alone
    a_busy_ignore: assert property ((cs_rise && cr.st[ST_BUSY] && cr.tmr > TMR_W'(1)) // RULE24
        |=> $stable(cr.st))
        else $error("command acted during write cycle");
    a_pgm_safe: assert property (cr.start |-> cr.st[ST_BUSY] // RULE15
        && !prot_hit(cr.st[ST_BP_HI:ST_BP_LO], cr.paddr, cr.pid))
        else $error("protected region programmed");
    a_busy_std_len: assert property (bcnt <= TMR_W'(WC_STD_CYCLES)) // RULE17
        else $error("write cycle too long");
    a_busy_fast_len: assert property ((cr.st[ST_BUSY] && cr.pfast) // RULE16
        |-> bcnt <= TMR_W'(WC_FAST_CYCLES))
        else $error("fast write cycle too long");
    a_idsel_clear: assert property (s_commit(CMD_MEM_RD) |=> !cr.st[ST_IDSEL]) // RULE20
        else $error("id select not cleared");
    a_hold_freeze: assert property (@(posedge spi_sck) disable iff (lk_clr) // RULE6
        !hold_n |=> $stable(lk.cnt) && $stable(lk.phase))
        else $error("sequence moved during pause");
endmodule // eec_top

// >>> eec_host.sv
`timescale 1ns/1ps
// host serial master; the clock stands still outside frames
module eec_host
(
    output logic spi_sck,
    output logic cs_n,
    output logic si,
    output logic hold_n,
    input wire logic so_out,
    input wire logic so_oe
);
    logic cpol = 1'b0;
    initial
    begin
        spi_sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
    end
    // ==========================================================
    // one frame, msb first; a bit taken while the output is off reads x
    task automatic xfer(input logic [63:0] tx, input int n, input int hold_at,
        output logic [63:0] rx);
        rx = '0;
        spi_sck = cpol;
        #20 cs_n = 1'b0;
        #60;
        for (int i = n - 1; i >= 0; i--)
        begin
            spi_sck = 1'b0;
            si = tx[i];
            if (i == hold_at)
            begin
                // a clock pulse and a flipped bit inside the pause must be ignored
                hold_n = 1'b0;
                #6 si = ~tx[i];
                #6 spi_sck = 1'b1;
                #6 spi_sck = 1'b0;
                #6 si = tx[i];
                #40 hold_n = 1'b1;
            end
            #6 spi_sck = 1'b1;
            rx = {rx[62:0], so_oe ? so_out : 1'bx};
            #6;
        end
        spi_sck = cpol;
        #60 cs_n = 1'b1;
        si = ~si;
        #500;
    endtask
endmodule // eec_host

// >>> test_spi_eeprom_command_status.sv
`timescale 1ns/1ps
module test_spi_eeprom_command_status;
    import eec_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic wp_n = 1'b1;
    logic spi_sck, cs_n, si, hold_n, so_out, so_oe, rd_id, load_we, pgm_start, pgm_id, pgm_fast;
    logic [7:0] rd_data, load_data, load_idx, status;
    logic [ARRAY_BITS-1:0] rd_addr, pgm_addr;
    logic [63:0] rx;
    logic rid_seen;
    logic [7:0] seed = 8'h26;
    logic [15:0] loads[$];
    logic [15:0] pgms[$];
    int num_errors = 0;
    int tests_run = 0;
    int st = 0;
    always #50 ref_clk = ~ref_clk;
    // array stand-in: data is a fixed function of the address
    assign rd_data = rd_addr[7:0] ^ 8'h5a;
    always @(negedge spi_sck) if (load_we) loads.push_back({load_idx, load_data});
    always @(negedge spi_sck) rid_seen <= rd_id;
    always @(posedge ref_clk)
        if (pgm_start) pgms.push_back({pgm_fast, pgm_id, 4'h0, pgm_addr[17:8]});
    eec_top #(.WC_STD_CYCLES(40), .WC_FAST_CYCLES(12)) u_dut (.ref_clk(ref_clk), .rst(rst),
        .spi_sck(spi_sck), .cs_n(cs_n), .si(si), .so_out(so_out), .so_oe(so_oe), .wp_n(wp_n),
        .hold_n(hold_n), .rd_data(rd_data), .rd_addr(rd_addr), .rd_id(rd_id), .load_we(load_we),
        .load_idx(load_idx), .load_data(load_data), .pgm_start(pgm_start), .pgm_addr(pgm_addr),
        .pgm_id(pgm_id), .pgm_fast(pgm_fast), .status(status));
    eec_host u_host (.spi_sck(spi_sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
        .so_out(so_out), .so_oe(so_oe));
    // ==========================================================
    // helpers
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmd(input logic [7:0] op, input int n);
        u_host.xfer(64'(op), n, -1, rx);
    endtask
    task automatic rdst(input string what);
        u_host.xfer(64'h0500, 16, 12, rx);
        chk(what, 16'(st[7:0]), {8'h00, rx[7:0]});
        chk("status port", 16'(st[7:0]), {8'h00, status});
        $display("test %s done", what);
    endtask
    task automatic wait_busy(input logic lvl);
        for (int k = 0; status[0] !== lvl; k++)
        begin
            if (k == 300)
            begin
                num_errors++;
                $display("wrong value busy expected %b seen timeout", lvl);
                final_report();
            end
            @(posedge ref_clk);
        end
    endtask
    // busy is expected as the cycle starts; a command inside it must be ignored
    task automatic cycle_end;
        wait_busy(1'b1);
        cmd(8'h06, 8);
        wait_busy(1'b0);
        st = st & 8'hfc;
    endtask
    task automatic stwr(input logic [7:0] d);
        int nxt;
        cmd(8'h06, 8);
        st = st | 2;
        u_host.xfer(64'({8'h01, d}), 16, -1, rx);
        nxt = (d & 8'hfc) | (st & 3);
        if (d[6] && d[4])
            nxt = (nxt & 8'haf) | (st & 8'h50);
        if (!wp_n && st[7])
        begin
            cmd(8'h04, 8);
            st = st & 8'hfd;
        end
        else
        begin
            cycle_end();
            st = nxt & 8'hfc;
        end
        rdst("status write");
    endtask
    task automatic mw(input logic [23:0] a, input logic prot);
        seed = lfsr(seed);
        cmd(8'h06, 8);
        u_host.xfer(64'({8'h02, a, seed, ~seed}), 48, -1, rx);
        chk("load first", {a[7:0], seed}, loads.pop_front());
        chk("load wrap", {a[7:0] + 8'h01, ~seed}, loads.pop_front());
        if (!prot)
        begin
            cycle_end();
            chk("page", {st[5], 1'b0, 4'h0, a[17:8]}, pgms.pop_front());
        end
        else
        begin
            repeat (20) @(posedge ref_clk);
            chk("refused write", 16'h0000, 16'(pgms.size()));
            cmd(8'h04, 8);
            st = st & 8'hfd;
        end
        rdst("memory write");
    endtask
    // ==========================================================
    // sequence
    initial
    begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rdst("reset");
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            cmd(seed | 8'h80, 8);
        end
        rdst("unknown codes");
        cmd(8'h06, 8);
        st = 2;
        rdst("latch set");
        cmd(8'h01, 12);
        rdst("cut frame");
        cmd(8'h04, 8);
        st = 0;
        rdst("latch clear");
        stwr(8'h7b);
        mw(24'hc1_23ff, 1'b0);
        mw(24'h02_8000, 1'b1);
        u_host.cpol = 1'b1;
        u_host.xfer(64'h03_3f12_3400, 40, -1, rx);
        chk("read data", 16'h006e, {8'h00, rx[7:0]});
        chk("id route", 16'h0000, {15'h0000, rid_seen});
        $display("test mode three read done");
        u_host.cpol = 1'b0;
        stwr(8'h88);
        @(posedge ref_clk) wp_n <= 1'b0;
        stwr(8'h80);
        @(posedge ref_clk) wp_n <= 1'b1;
        stwr(8'h00);
        stwr(8'h40);
        u_host.xfer(64'h03_0000_4100, 40, -1, rx);
        chk("id read", 16'h001b, {8'h00, rx[7:0]});
        chk("id route", 16'h0001, {15'h0000, rid_seen});
        st = 0;
        rdst("id select clear");
        final_report();
    end
endmodule // test_spi_eeprom_command_status
